// >>> common/irap_consts.vh
`ifndef IRAP_CONSTS_VH
`define IRAP_CONSTS_VH

// register byte offsets
`define IRAP_OFS_SEL        8'h24
`define IRAP_OFS_CMD        8'h28
`define IRAP_OFS_ADDR       8'h2c
`define IRAP_OFS_DATA       8'h30

// field positions and widths
`define IRAP_IDLE_BIT       31
`define IRAP_SEL_W          4
`define IRAP_ADDR_W         14
`define IRAP_DATA_W         32
`define IRAP_CMD_WRITE_BIT  0

// reset values
`define IRAP_SEL_RST        4'h0
`define IRAP_CMD_RST        1'h0
`define IRAP_ADDR_RST       14'h0000
`define IRAP_DATA_RST       32'h00000000

// ram target codes
`define IRAP_TGT_RXBUF      4'h0
`define IRAP_TGT_HASH       4'h1
`define IRAP_TGT_HDR        4'h2
`define IRAP_TGT_FCTRX      4'h3
`define IRAP_TGT_FCTTX      4'h4
`define IRAP_TGT_DESC       4'h5
`define IRAP_TGT_TXBUF      4'h7

// each internal ram is modelled with this many address bits
`define IRAP_RAM_AW         8
`define IRAP_NUM_RAMS       8

`endif

// >>> hw/irap_ram.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// storage for all selectable rams, one flat array indexed by target
// ----------------------------------------------------------------
module irap_ram
(
    input  wire        clk,
    input  wire        wrEn,
    input  wire        rdEn,
    input  wire [10:0] addr,
    input  wire [31:0] wrData,
    output reg  [31:0] rdData
);

    reg [31:0] mem [0:2047];

    // read data registered; no reset so it can map to block ram
    always @(posedge clk)
    begin
        if (wrEn)
        begin
            mem[addr] <= wrData;
        end
        if (rdEn)
        begin
            rdData <= mem[addr];
        end
    end

endmodule

`default_nettype wire

// >>> hw/irap_port.v
// Summary of operation
// R1 - bit 31 of selector reports access done
// R2 - idle flag 1 at idle/reset, 0 busy
// R3 - bits 3:0 select the target ram; the ram address takes only bits 2:0, so codes 8-15 alias onto 0-7
// R4 - software avoids non-hash rams at run time
// R5 - command write starts access, bit0 direction
// R6 - software loads address/data before command
// R7 - 14-bit word address, upper bits read zero
// R8 - data register holds write or read word
// R9 - software polls idle before taking read data
// R10 - flag clears next cycle, sets on completion
`timescale 1ns/10ps
`default_nettype none
`include "irap_consts.vh"

module irap_port
(
    input  wire        clk,
    input  wire        rst,
    input  wire [7:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [3:0]  avsByteEnable,
    input  wire [31:0] avsWriteData,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_ISSUE = 2'd1;
    localparam [1:0] ST_FETCH = 2'd2;
    localparam [1:0] ST_DONE  = 2'd3;

    reg [1:0]  state_ff;
    reg [1:0]  nxt_state;
    reg [3:0]  sel_ff;
    reg        cmdWrite_ff;
    reg [13:0] wordAddr_ff;
    reg [31:0] wordValue_ff;
    reg        rdAck_ff;

    wire [31:0] ramRdData;
    wire        portIdle;
    wire        rdLaunch;
    wire        cmdHit;
    wire        cmdStart;
    wire        selHit;
    wire        addrHit;
    wire        dataHit;
    wire        ramWrEn;
    wire        ramRdEn;
    wire [10:0] ramAddr;
    wire [31:0] beMask;

    // readback images of the narrow registers
    wire [31:0] selWord;
    wire [31:0] cmdWord;
    wire [31:0] addrWord;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [31:0] merge_bytes;
        input [31:0] oldVal;
        input [31:0] newVal;
        input [3:0]  be;
        integer i;
        begin
            merge_bytes = oldVal;
            for (i = 0; i < 4; i = i + 1)
            begin
                if (be[i])
                begin
                    merge_bytes[i*8 +: 8] = newVal[i*8 +: 8];
                end
            end
        end
    endfunction

    // one bus write landing on one register offset; lane checks stay with the caller
    function wr_hit;
        input       wr;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            wr_hit = wr && (adr == ofs);
        end
    endfunction

    assign beMask = merge_bytes(32'h00000000, 32'hffffffff, avsByteEnable);

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // writes finish in their first cycle; reads wait one cycle for the
    // registered read mux so the answer never depends on a combinational path
    assign rdLaunch       = avsRead & ~rdAck_ff;
    assign avsWaitRequest = rdLaunch;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdAck_ff <= 1'b0;
        end
        else
        begin
            rdAck_ff <= rdLaunch;
        end
    end

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    assign portIdle = (state_ff == ST_IDLE); // R2
    assign selHit   = wr_hit(avsWrite, avsAddress, `IRAP_OFS_SEL);
    assign addrHit  = wr_hit(avsWrite, avsAddress, `IRAP_OFS_ADDR);
    assign dataHit  = wr_hit(avsWrite, avsAddress, `IRAP_OFS_DATA);
    // only byte lane 0 carries the direction bit
    assign cmdHit   = wr_hit(avsWrite, avsAddress, `IRAP_OFS_CMD) && avsByteEnable[0];
    // a command arriving while busy is dropped; software must poll idle first
    assign cmdStart = cmdHit && portIdle; // R10

    // readback images; reserved bits always read as zero
    assign selWord  = {portIdle, 27'h0000000, sel_ff}; // R1
    assign cmdWord  = {31'h00000000, cmdWrite_ff};
    assign addrWord = {18'h00000, wordAddr_ff}; // R7

    // reserved and unmapped offsets answer zero
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            avsReadData <= 32'h00000000;
        end
        else if (rdLaunch)
        begin
            case (avsAddress)
                `IRAP_OFS_SEL:
                begin
                    avsReadData <= selWord; // R1
                end
                `IRAP_OFS_CMD:
                begin
                    avsReadData <= cmdWord; // R5
                end
                `IRAP_OFS_ADDR:
                begin
                    avsReadData <= addrWord; // R7
                end
                `IRAP_OFS_DATA:
                begin
                    avsReadData <= wordValue_ff; // R8
                end
                default:
                begin
                    avsReadData <= 32'h00000000;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // the selector field sits in the low byte, so it needs lane 0
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_ff <= `IRAP_SEL_RST;
        end
        else if (selHit && avsByteEnable[0])
        begin
            sel_ff <= avsWriteData[`IRAP_SEL_W-1:0]; // R3
        end
    end

    // the direction bit is stored even when a command arriving while busy is dropped
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmdWrite_ff <= `IRAP_CMD_RST;
        end
        else if (cmdHit)
        begin
            cmdWrite_ff <= avsWriteData[`IRAP_CMD_WRITE_BIT]; // R5
        end
    end

    // partial writes merge per byte lane
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wordAddr_ff <= `IRAP_ADDR_RST;
        end
        else if (addrHit)
        begin
            wordAddr_ff <= (wordAddr_ff & ~beMask[13:0])
                         | (avsWriteData[13:0] & beMask[13:0]); // R7
        end
    end

    // captured read word wins over a bus write landing the same cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wordValue_ff <= `IRAP_DATA_RST;
        end
        else if (state_ff == ST_FETCH)
        begin
            wordValue_ff <= ramRdData; // R8
        end
        else if (dataHit)
        begin
            wordValue_ff <= merge_bytes(wordValue_ff, avsWriteData, avsByteEnable);
        end
    end

    // ----------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------
    // read: issue, fetch, done; write: issue, done; the flag is low in all of them
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (cmdStart)
                begin
                    nxt_state = ST_ISSUE; // R10
                end
            end
            ST_ISSUE:
            begin
                // a write needs no fetch slot, the ram takes the word this cycle
                if (cmdWrite_ff)
                begin
                    nxt_state = ST_DONE;
                end
                else
                begin
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                nxt_state = ST_DONE;
            end
            ST_DONE:
            begin
                nxt_state = ST_IDLE; // R10
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state; // R10
        end
    end

    // ----------------------------------------------------------------
    // ram port
    // ----------------------------------------------------------------
    // ram word write or read launch happens in the issue cycle
    assign ramWrEn = (state_ff == ST_ISSUE) && cmdWrite_ff; // R5
    assign ramRdEn = (state_ff == ST_ISSUE) && !cmdWrite_ff; // R8

    // limitation: only the low address bits are backed by storage here,
    // so words further up alias onto the same cells
    assign ramAddr = {sel_ff[2:0], wordAddr_ff[`IRAP_RAM_AW-1:0]}; // R3

    irap_ram uRam
    (
        .clk    (clk),
        .wrEn   (ramWrEn),
        .rdEn   (ramRdEn),
        .addr   (ramAddr),
        .wrData (wordValue_ff),
        .rdData (ramRdData)
    );

endmodule

`default_nettype wire

// >>> tb/irap_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module irap_port_chk
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [3:0]  avsByteEnable,
    input wire logic [31:0] avsWriteData,
    input wire logic [31:0] avsReadData,
    input wire logic        avsWaitRequest
);
    wire logic ans = avsRead && !avsWaitRequest;
    wire logic mapped = avsAddress inside {8'h24, 8'h28, 8'h2c, 8'h30};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_write_nowait: assert property (avsWrite |-> !avsWaitRequest)
        else $error("write stalled");
    chk_read_stall: assert property ($rose(avsRead) |-> avsWaitRequest)
        else $error("read answered without wait");
    chk_read_answer: assert property (avsRead && avsWaitRequest |=> !avsWaitRequest)
        else $error("read answer late");
    chk_idle_nowait: assert property (!avsRead |-> !avsWaitRequest)
        else $error("wait without read");
    chk_sel_rsvd: assert property (ans && avsAddress == 8'h24 |-> avsReadData[30:4] == 0)
        else $error("selector reserved bits set");
    chk_cmd_rsvd: assert property (ans && avsAddress == 8'h28 |-> avsReadData[31:1] == 0)
        else $error("command reserved bits set");
    chk_addr_rsvd: assert property (ans && avsAddress == 8'h2c |-> avsReadData[31:14] == 0)
        else $error("address reserved bits set");
    chk_unmapped_zero: assert property (ans && !mapped |-> avsReadData == 0)
        else $error("unmapped read not zero");
    chk_data_hold: assert property (!avsRead |=> $stable(avsReadData))
        else $error("read data moved");
endmodule
bind irap_port irap_port_chk chk_u (.clk(clk), .rst(rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsByteEnable(avsByteEnable),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));
`default_nettype wire

// >>> tb/indirect_ram_access_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module indirect_ram_access_port_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avsAddress = 8'h00;
    logic        avsRead = 1'b0;
    logic        avsWrite = 1'b0;
    logic [3:0]  avsByteEnable = 4'hf;
    logic [31:0] avsWriteData = 32'h0;
    wire  [31:0] avsReadData;
    wire         avsWaitRequest;
    int          n_mismatch = 0;
    int          comparisons = 0;
    logic [31:0] rdv;
    logic [31:0] rnd;
    logic [31:0] mem [0:6];
    logic [13:0] wa [0:6];
    logic [3:0]  tg [0:6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
    always #25 clk = ~clk;
    irap_port dut_u (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsByteEnable(avsByteEnable), .avsWriteData(avsWriteData),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest));
    // ----------------------------------------
    // bus helpers
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // the extra edge after release keeps a following call from re-driving in the same step
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWriteData <= d;
        avsRead <= rd;
        avsWrite <= !rd;
        do @(posedge clk); while (avsWaitRequest);
        rdv = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        do
        begin
            bus(1, 8'h24, 0);
            n++;
        end
        while (!rdv[31] && n < 20);
        check("idle", rdv[31], 1);
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        void'($urandom(36339));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1, 8'h24, 0);
        check("sel rst", rdv, 32'h80000000);
        bus(1, 8'h28, 0);
        check("cmd rst", rdv, 0);
        bus(1, 8'h2c, 0);
        check("addr rst", rdv, 0);
        bus(1, 8'h30, 0);
        check("data rst", rdv, 0);
        bus(1, 8'h34, 0);
        check("unmapped", rdv, 0);
        bus(0, 8'h2c, 32'hffffffff);
        bus(1, 8'h2c, 0);
        check("addr rsvd", rdv, 32'h3fff);
        // each of the seven coded rams (not code 6) is reached here only while nothing else runs
        for (int i = 0; i < 7; i++)
        begin
            wa[i] = 14'($urandom);
            mem[i] = $urandom;
            bus(0, 8'h24, tg[i]);
            bus(0, 8'h2c, wa[i]);
            bus(0, 8'h30, mem[i]);
            bus(0, 8'h28, 1);
            waitIdle();
            check("sel", rdv, {28'h8000000, tg[i]});
            bus(1, 8'h28, 0);
            check("dir wr", rdv, 1);
        end
        for (int i = 0; i < 7; i++)
        begin
            bus(0, 8'h24, tg[i]);
            bus(0, 8'h2c, wa[i]);
            bus(0, 8'h30, 0);
            bus(0, 8'h28, 0);
            bus(1, 8'h24, 0);
            check("busy", rdv[31], 0);
            waitIdle();
            bus(1, 8'h30, 0);
            check("word", rdv, mem[i]);
            bus(1, 8'h28, 0);
            check("dir rd", rdv, 0);
        end
        // partial lanes: data merges per byte, a command without lane 0 is dropped
        rnd = $urandom;
        avsByteEnable <= 4'h5;
        bus(0, 8'h30, rnd);
        avsByteEnable <= 4'he;
        bus(0, 8'h28, 1);
        avsByteEnable <= 4'hf;
        bus(1, 8'h24, 0);
        check("no start", rdv, 32'h80000007);
        bus(1, 8'h28, 0);
        check("dir kept", rdv, 0);
        bus(1, 8'h30, 0);
        check("lanes", rdv, {mem[6][31:24], rnd[23:16], mem[6][15:8], rnd[7:0]});
        // reset in the middle of a read access must leave the port idle
        bus(0, 8'h28, 0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1, 8'h24, 0);
        check("sel rerst", rdv, 32'h80000000);
        bus(1, 8'h30, 0);
        check("data rerst", rdv, 0);
        summarize();
    end
endmodule
`default_nettype wire
